// >>> hw/smbs_consts.svh
// constants for the mode register fields and command timing of the dram core
`ifndef SMBS_CONSTS_SVH
`define SMBS_CONSTS_SVH

// operating_mode_config field positions
`define SMBS_BL_LSB 0
`define SMBS_BL_MSB 2
`define SMBS_BT_BIT 3
`define SMBS_CL_LSB 4
`define SMBS_CL_MSB 6
`define SMBS_OPM_LSB 7
`define SMBS_OPM_MSB 8
`define SMBS_WB_BIT 9
`define SMBS_MODE_RESET 12'h000

// burst length codes
`define SMBS_BL_1 3'h0
`define SMBS_BL_2 3'h1
`define SMBS_BL_4 3'h2
`define SMBS_BL_8 3'h3
`define SMBS_BL_FULL 3'h7

// read latency code for two clocks; every other code runs at three
`define SMBS_CL_2 3'h2

// address bit that selects all banks on a precharge
`define SMBS_ALL_BANKS_BIT 10

// latency of the clock enable, in cycles, entry and exit alike
`define SMBS_GATE_LATENCY 1

`endif

// >>> hw/smbs_pkg.sv
// types shared by the dram core: command codes and burst states
`default_nettype none
package smbs_pkg;
  // command on {row strobe, column strobe, write enable} with chip select low
  typedef enum logic [2:0] {
    SMBS_CMD_LOAD_MODE = 3'h0,
    SMBS_CMD_REFRESH   = 3'h1,
    SMBS_CMD_PRECHARGE = 3'h2,
    SMBS_CMD_ACTIVATE  = 3'h3,
    SMBS_CMD_WRITE     = 3'h4,
    SMBS_CMD_READ      = 3'h5,
    SMBS_CMD_STOP      = 3'h6,
    SMBS_CMD_NOP       = 3'h7
  } smbs_cmd_t;

  typedef enum logic [1:0] {
    SMBS_BST_IDLE  = 2'h0,
    SMBS_BST_READ  = 2'h1,
    SMBS_BST_WRITE = 2'h2
  } smbs_bst_t;
endpackage
`default_nettype wire

// >>> hw/smbs_core.sv
// synchronous dram core: mode register, bursts, byte masks and clock gating
`include "smbs_consts.svh"
`default_nettype none
module smbs_core #(
  parameter int ROW_W = 12,
  parameter int COL_W = 8,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [11:0] row_column_address_lines,
  input wire logic [1:0] byte_mask,
  // data pins, one output enable per byte lane
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [1:0] dq_oe_n,
  // write buffer back-pressure
  output logic write_buf_ready
);
  localparam int AW = 2 + ROW_W + COL_W;

  // 4 banks x rows x columns of words
  logic [DATA_W-1:0] mem [2**AW];

  logic cke_ff, nxt_cke;
  logic [11:0] mode_ff, nxt_mode;
  logic mode_ok_ff, nxt_mode_ok;
  logic [ROW_W-1:0] row_ff [4];
  logic [ROW_W-1:0] nxt_row [4];
  smbs_pkg::smbs_bst_t bst_ff, nxt_bst;
  logic [1:0] bbank_ff, nxt_bbank;
  logic [COL_W-1:0] bstart_ff, nxt_bstart, bcnt_ff, nxt_bcnt, bmask_ff, nxt_bmask;
  logic bfull_ff, nxt_bfull;
  logic [DATA_W-1:0] memq_ff, d2_ff, nxt_d2, nxt_dq_out;
  logic rv1_ff, nxt_rv1, rv2_ff, nxt_rv2;
  logic [1:0] dqm_ff, nxt_dqm, nxt_dq_oe_n;
  logic [AW-1:0] qa_ff [2];
  logic [AW-1:0] nxt_qa [2];
  logic [DATA_W-1:0] qd_ff [2];
  logic [DATA_W-1:0] nxt_qd [2];
  logic [1:0] qm_ff [2];
  logic [1:0] nxt_qm [2];
  logic qwr_ff, nxt_qwr, qrd_ff, nxt_qrd;
  logic [1:0] qcnt_ff, nxt_qcnt;

  logic en, cmd_on, all_idle, cl2;
  smbs_pkg::smbs_cmd_t cmd;
  logic [1:0] cmd_bank;
  logic issue_rd, issue_wr, push, drain;
  logic [COL_W-1:0] beat_col, beat_mask, beat_cnt, beat_start;
  logic [1:0] beat_bank;
  logic [AW-1:0] beat_addr;

  // mask of the column bits that move inside a burst
  function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
    case (code)
      `SMBS_BL_2: len_mask = COL_W'(1);
      `SMBS_BL_4: len_mask = COL_W'(3);
      `SMBS_BL_8: len_mask = COL_W'(7);
      `SMBS_BL_FULL: len_mask = '1;
      default: len_mask = '0;
    endcase
  endfunction

  // the internal clock follows the enable sampled one edge earlier
  assign en = cke_ff;
  assign cmd_on = en && !cs_n;
  // command decode
  assign cmd = smbs_pkg::smbs_cmd_t'({ras_n, cas_n, we_n});
  assign cmd_bank = {bank_select_high, bank_select_low};
  assign all_idle = (bst_ff == smbs_pkg::SMBS_BST_IDLE);
  assign cl2 = (mode_ff[`SMBS_CL_MSB:`SMBS_CL_LSB] == `SMBS_CL_2);
  assign nxt_cke = cke;

  // mode register and open rows
  always_comb begin
    nxt_mode = mode_ff;
    nxt_mode_ok = mode_ok_ff;
    nxt_row = row_ff;
    // loads while a burst runs are ignored
    if (cmd_on && cmd == smbs_pkg::SMBS_CMD_LOAD_MODE && all_idle) begin
      nxt_mode = row_column_address_lines;
      nxt_mode_ok = 1'b1;
    end
    if (cmd_on && cmd == smbs_pkg::SMBS_CMD_ACTIVATE && mode_ok_ff) begin
      nxt_row[cmd_bank] = row_column_address_lines[ROW_W-1:0];
    end
  end

  // burst sequencer: one beat per enabled edge, new command wins
  always_comb begin
    logic stop_now, new_col;
    stop_now = 1'b0;
    new_col = 1'b0;
    nxt_bst = bst_ff;
    nxt_bbank = bbank_ff;
    nxt_bstart = bstart_ff;
    nxt_bcnt = bcnt_ff;
    nxt_bmask = bmask_ff;
    nxt_bfull = bfull_ff;
    issue_rd = 1'b0;
    issue_wr = 1'b0;
    beat_bank = bbank_ff;
    beat_start = bstart_ff;
    beat_cnt = bcnt_ff;
    beat_mask = bmask_ff;
    if (cmd_on) begin
      // a stop, or a precharge of the burst's bank, ends it at this edge
      stop_now = (cmd == smbs_pkg::SMBS_CMD_STOP) ||
        (cmd == smbs_pkg::SMBS_CMD_PRECHARGE &&
         (row_column_address_lines[`SMBS_ALL_BANKS_BIT] || cmd_bank == bbank_ff));
      new_col = mode_ok_ff &&
        (cmd == smbs_pkg::SMBS_CMD_READ || cmd == smbs_pkg::SMBS_CMD_WRITE);
    end
    if (new_col) begin
      beat_bank = cmd_bank;
      beat_start = row_column_address_lines[COL_W-1:0];
      beat_cnt = '0;
      beat_mask = len_mask(mode_ff[`SMBS_BL_MSB:`SMBS_BL_LSB]);
      nxt_bfull = (mode_ff[`SMBS_BL_MSB:`SMBS_BL_LSB] == `SMBS_BL_FULL);
      if (cmd == smbs_pkg::SMBS_CMD_WRITE && mode_ff[`SMBS_WB_BIT]) begin
        beat_mask = '0;
        nxt_bfull = 1'b0;
      end
      issue_rd = (cmd == smbs_pkg::SMBS_CMD_READ);
      issue_wr = !issue_rd;
      nxt_bbank = beat_bank;
      nxt_bstart = beat_start;
      nxt_bmask = beat_mask;
      nxt_bst = issue_rd ? smbs_pkg::SMBS_BST_READ : smbs_pkg::SMBS_BST_WRITE;
    end else if (en && !all_idle && !stop_now) begin
      issue_rd = (bst_ff == smbs_pkg::SMBS_BST_READ);
      issue_wr = (bst_ff == smbs_pkg::SMBS_BST_WRITE);
    end else if (stop_now) begin
      nxt_bst = smbs_pkg::SMBS_BST_IDLE;
    end
    if (issue_rd || issue_wr) begin
      nxt_bcnt = beat_cnt + COL_W'(1);
      // full page never ends by itself and wraps inside the page
      if (beat_cnt == beat_mask && !nxt_bfull) begin
        nxt_bst = smbs_pkg::SMBS_BST_IDLE;
      end
    end
    // interleaved order is not offered for full page, so it runs sequential
    if (mode_ff[`SMBS_BT_BIT] && !nxt_bfull) begin
      beat_col = (beat_start & ~beat_mask) | ((beat_start ^ beat_cnt) & beat_mask);
    end else begin
      beat_col = (beat_start & ~beat_mask) | ((beat_start + beat_cnt) & beat_mask);
    end
    beat_addr = {beat_bank, row_ff[beat_bank], beat_col};
  end

  // read pipeline: latency two or three, driving from the edge before
  always_comb begin
    logic flush;
    flush = cmd_on && cmd == smbs_pkg::SMBS_CMD_WRITE && mode_ok_ff;
    nxt_rv1 = rv1_ff;
    nxt_rv2 = rv2_ff;
    nxt_d2 = d2_ff;
    nxt_dqm = dqm_ff;
    nxt_dq_out = dq_out;
    nxt_dq_oe_n = dq_oe_n;
    if (en) begin
      nxt_rv1 = issue_rd;
      nxt_rv2 = rv1_ff && !flush;
      nxt_d2 = memq_ff;
      nxt_dqm = byte_mask;
      nxt_dq_out = cl2 ? memq_ff : d2_ff;
      // mask seen one edge ago gates the lanes valid at the next edge
      nxt_dq_oe_n = {2{!(cl2 ? rv1_ff : rv2_ff) || flush}} | dqm_ff;
    end
  end

  // two-entry write buffer; the array port is shared with read fetches,
  // so a read beat stalls the drain; it pushes nothing, so the buffer never holds two words
  always_comb begin
    nxt_qa = qa_ff;
    nxt_qd = qd_ff;
    nxt_qm = qm_ff;
    write_buf_ready = (qcnt_ff != 2'h2);
    push = issue_wr && write_buf_ready;
    drain = (qcnt_ff != 2'h0) && !issue_rd;
    if (push) begin
      nxt_qa[qwr_ff] = beat_addr;
      nxt_qd[qwr_ff] = dq_in;
      nxt_qm[qwr_ff] = byte_mask;
    end
    nxt_qwr = qwr_ff ^ push;
    nxt_qrd = qrd_ff ^ drain;
    nxt_qcnt = qcnt_ff + {1'b0, push} - {1'b0, drain};
  end

  always_ff @(posedge mclk) begin
    if (issue_rd) begin
      memq_ff <= mem[beat_addr];
    end
    if (drain) begin
      for (int b = 0; b < 2; b++) begin
        if (!qm_ff[qrd_ff][b]) begin
          mem[qa_ff[qrd_ff]][b*8 +: 8] <= qd_ff[qrd_ff][b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cke_ff <= 1'b0;
      mode_ff <= `SMBS_MODE_RESET;
      mode_ok_ff <= 1'b0;
      bst_ff <= smbs_pkg::SMBS_BST_IDLE;
      bbank_ff <= 2'h0;
      bstart_ff <= '0;
      bcnt_ff <= '0;
      bmask_ff <= '0;
      bfull_ff <= 1'b0;
      rv1_ff <= 1'b0;
      rv2_ff <= 1'b0;
      d2_ff <= '0;
      dqm_ff <= 2'h3;
      dq_out <= '0;
      dq_oe_n <= 2'h3;
      qwr_ff <= 1'b0;
      qrd_ff <= 1'b0;
      qcnt_ff <= 2'h0;
    end else begin
      cke_ff <= nxt_cke;
      mode_ff <= nxt_mode;
      mode_ok_ff <= nxt_mode_ok;
      bst_ff <= nxt_bst;
      bbank_ff <= nxt_bbank;
      bstart_ff <= nxt_bstart;
      bcnt_ff <= nxt_bcnt;
      bmask_ff <= nxt_bmask;
      bfull_ff <= nxt_bfull;
      rv1_ff <= nxt_rv1;
      rv2_ff <= nxt_rv2;
      d2_ff <= nxt_d2;
      dqm_ff <= nxt_dqm;
      dq_out <= nxt_dq_out;
      dq_oe_n <= nxt_dq_oe_n;
      qwr_ff <= nxt_qwr;
      qrd_ff <= nxt_qrd;
      qcnt_ff <= nxt_qcnt;
    end
  end

  // rows and queued words need no reset: nothing reads them before a write
  always_ff @(posedge mclk) begin
    row_ff <= nxt_row;
    qa_ff <= nxt_qa;
    qd_ff <= nxt_qd;
    qm_ff <= nxt_qm;
  end
endmodule
`default_nettype wire

// >>> testbench/smbs_core_asserts.sv
// checker: output timing against commands, masks and clock enable
`include "smbs_consts.svh"
`default_nettype none
module smbs_core_chk #(parameter int DATA_W = 16) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] row_column_address_lines,
  input wire logic [1:0] byte_mask,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic [1:0] dq_oe_n
);
  logic en_ff, go, rd, pre, qt, cl2;
  logic [2:0] c;
  logic [11:0] md_ff;
  assign c = {ras_n, cas_n, we_n};
  assign go = en_ff && !cs_n;
  assign rd = go && c == smbs_pkg::SMBS_CMD_READ && md_ff[5] && byte_mask == 2'h0;
  assign pre = go && c == smbs_pkg::SMBS_CMD_PRECHARGE && row_column_address_lines[10];
  assign qt = en_ff && (cs_n || c == smbs_pkg::SMBS_CMD_NOP) && byte_mask == 2'h0;
  assign cl2 = md_ff[6:4] == `SMBS_CL_2;
  // latency codes 2 and 3 both set bit 5, so it marks a loaded mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_ff <= 1'b0;
      md_ff <= 12'h000;
    end else begin
      en_ff <= cke;
      if (go && c == smbs_pkg::SMBS_CMD_LOAD_MODE) md_ff <= row_column_address_lines;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  AST_MASK_LOW: assert property (en_ff && byte_mask[0] ##1 en_ff |=> dq_oe_n[0])
    else $error("low lane not floated");
  AST_MASK_HIGH: assert property (en_ff && byte_mask[1] ##1 en_ff |=> dq_oe_n[1])
    else $error("high lane not floated");
  AST_RD_CL2: assert property (rd && cl2 ##1 qt |=> dq_oe_n == 2'h0)
    else $error("read not driving at latency two");
  AST_RD_CL3: assert property (rd && !cl2 ##1 qt [*2] |=> dq_oe_n == 2'h0)
    else $error("read not driving at latency three");
  AST_PRE_CL2: assert property (pre && cl2 ##1 qt |=> dq_oe_n == 2'h3)
    else $error("outputs driven after precharge");
  AST_PRE_CL3: assert property (pre && !cl2 ##1 qt ##1 qt |=> &dq_oe_n)
    else $error("outputs driven after precharge");
  AST_FREEZE: assert property (!en_ff |=> $stable(dq_out) && $stable(dq_oe_n))
    else $error("outputs moved while clock gated");
  AST_NO_MODE: assert property (!md_ff[5] |-> dq_oe_n == 2'h3)
    else $error("outputs driven before mode load");
endmodule
bind smbs_core smbs_core_chk #(.DATA_W(DATA_W)) u_chk (.mclk(mclk), .reset(reset),
  .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .byte_mask(byte_mask),
  .row_column_address_lines(row_column_address_lines), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
`default_nettype wire

// >>> testbench/smbs_ctl_model.sv
// controller model: power-up, mode loads, one command a cycle
`default_nettype none
module smbs_ctl_model #(parameter int PWR_WAIT = 10000) (
  // pins
  input wire logic mclk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [11:0] row_column_address_lines,
  output logic [1:0] byte_mask,
  output logic [15:0] dq_in
);
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low} = 7'h7C;
    {row_column_address_lines, byte_mask, dq_in} = 30'h0;
  end
  task automatic cyc(smbs_pkg::smbs_cmd_t c, logic [11:0] a, logic [15:0] d, logic [1:0] m);
    @(negedge mclk);
    {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
    row_column_address_lines = a;
    dq_in = d;
    byte_mask = m;
  endtask
  // idle lines show their inverse so a stale word cannot pass
  task automatic idle(logic [1:0] m);
    cyc(smbs_pkg::SMBS_CMD_NOP, ~row_column_address_lines, ~dq_in, m);
  endtask
  task automatic pause(int n);
    repeat (n) @(negedge mclk) cke = 1'b0;
    @(negedge mclk) cke = 1'b1;
  endtask
  task automatic init();
    repeat (PWR_WAIT) idle(2'h0);
    cyc(smbs_pkg::SMBS_CMD_PRECHARGE, 12'h400, ~dq_in, 2'h0);
    repeat (2) begin
      repeat (7) idle(2'h0);
      cyc(smbs_pkg::SMBS_CMD_REFRESH, 12'h000, ~dq_in, 2'h0);
    end
  endtask
  task automatic setmode(logic [11:0] md);
    cyc(smbs_pkg::SMBS_CMD_PRECHARGE, 12'h400, ~dq_in, 2'h0);
    repeat (2) idle(2'h0);
    cyc(smbs_pkg::SMBS_CMD_LOAD_MODE, md & 12'hE7F, ~dq_in, 2'h0);
    repeat (2) idle(2'h0);
    cyc(smbs_pkg::SMBS_CMD_ACTIVATE, 12'h0A5, ~dq_in, 2'h0);
    repeat (2) idle(2'h0);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench: random bursts through the controller model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, cke, cs, ra, ca, we, bl, bh, wbr;
  logic [11:0] adr;
  logic [1:0] msk, oen;
  logic [15:0] din, dout;
  logic [15:0] lf = 16'h2F62;
  logic [15:0] mem [256];
  int n_mismatch = 0;
  int checks_done = 0;
  smbs_core u_dut (.mclk(mclk), .reset(reset), .cke(cke), .cs_n(cs), .ras_n(ra), .cas_n(ca),
    .we_n(we), .bank_select_low(bl), .bank_select_high(bh), .row_column_address_lines(adr),
    .byte_mask(msk), .dq_in(din), .dq_out(dout), .dq_oe_n(oen), .write_buf_ready(wbr));
  smbs_ctl_model u_ctl (.mclk(mclk), .cke(cke), .cs_n(cs), .ras_n(ra), .cas_n(ca), .we_n(we),
    .bank_select_low(bl), .bank_select_high(bh), .row_column_address_lines(adr),
    .byte_mask(msk), .dq_in(din));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [7:0] lmk(logic [2:0] bc);
    return bc == 3'h7 ? 8'hFF : 8'((1 << bc) - 1);
  endfunction
  function automatic logic [7:0] col(logic [7:0] s, logic [7:0] k, logic [2:0] bc, bit il);
    return il ? s ^ k : (s & ~lmk(bc)) | ((s + k) & lmk(bc));
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [7:0] s, logic [2:0] bc, bit il, bit sw);
    logic [15:0] d, bm;
    logic [7:0] a;
    u_ctl.setmode({2'h0, sw, 5'h03, il, bc});
    for (int k = 0; k <= lmk(bc); k++) begin
      d = rnd();
      bm = (k == 1 && bc == 3'h1) ? 16'h00FF : 16'h0000;
      a = col(s, 8'(k), bc, il);
      if (k == 0 || !sw) mem[a] = (mem[a] & bm) | (d & ~bm);
      u_ctl.cyc(k == 0 ? smbs_pkg::SMBS_CMD_WRITE : smbs_pkg::SMBS_CMD_NOP, {4'h0, s}, d,
        {1'b0, bm[0]});
    end
    repeat (5) u_ctl.idle(2'h0);
  endtask
  // full-page write cut by a stop one cycle after the last kept word
  task automatic wstop(logic [7:0] s);
    logic [15:0] d;
    u_ctl.setmode(12'h037);
    for (int k = 0; k < 3; k++) begin
      d = rnd();
      if (k < 2) mem[s + 8'(k)] = d;
      u_ctl.cyc(k == 0 ? smbs_pkg::SMBS_CMD_WRITE : k == 1 ? smbs_pkg::SMBS_CMD_NOP :
        smbs_pkg::SMBS_CMD_STOP, {4'h0, s}, d, 2'h0);
    end
    repeat (5) u_ctl.idle(2'h0);
  endtask
  task automatic rd(logic [7:0] s, logic [2:0] bc, bit il, int cl, logic [1:0] m, int p);
    int n;
    n = p > 0 ? p + cl + 1 : cl + lmk(bc) + 1;
    u_ctl.setmode({5'h00, cl == 2 ? 3'h2 : 3'h3, il, bc});
    u_ctl.cyc(smbs_pkg::SMBS_CMD_READ, {4'h0, s}, ~din, m);
    for (int j = 1; j <= n; j++) begin
      if (j == p) u_ctl.cyc(smbs_pkg::SMBS_CMD_PRECHARGE, 12'h400, ~din, m);
      else u_ctl.idle(m);
      if (j >= cl && j <= cl + lmk(bc) && (p == 0 || j <= p)) begin
        if (m == 2'h0) chk("dq_out", mem[col(s, 8'(j - cl), bc, il)], dout);
        chk("dq_oe_n", {14'h0, m}, {14'h0, oen});
      end
      if (j == n) chk("dq_oe_n end", 16'h0003, {14'h0, oen});
    end
  endtask
  initial begin
    reset = 1'b1;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    u_ctl.init();
    wr(8'h03, 3'h3, 1'b0, 1'b0);
    wr(8'h05, 3'h3, 1'b0, 1'b1);
    wr(8'h0D, 3'h3, 1'b1, 1'b0);
    wr(8'h09, 3'h0, 1'b0, 1'b0);
    wr(8'h0B, 3'h1, 1'b1, 1'b0);
    wr(8'h11, 3'h2, 1'b0, 1'b0);
    wstop(8'h20);
    chk("write_buf_ready", 16'h0001, {15'h0, wbr});
    u_ctl.pause(3);
    for (int i = 0; i < 16; i++)
      rd(8'(rnd() & 16'h000F), 3'(i % 4), i >= 8, 2 + (i / 4) % 2, i == 5 ? 2'h2 : 2'h0, 0);
    rd(8'h0E, 3'h7, 1'b0, 3, 2'h0, 5);
    rd(8'h06, 3'h3, 1'b1, 2, 2'h0, 4);
    rd(8'h20, 3'h1, 1'b0, 2, 2'h0, 0);
    stop_test();
  end
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
